// file: shared/ldsd_pkg.sv
`default_nettype none
package ldsd_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_COUNT = 8'h08;
   localparam logic [7:0] ADDR_LOW = 8'h0C;
   localparam logic [7:0] ADDR_HIGH = 8'h10;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int ST_OPCODE_ERR_BIT = 0;
   localparam int ST_PRED_RSVD_BIT = 1;
   localparam int ST_PHASE_BIT = 2;
   // Low word fields
   localparam int SEL0_LSB = 0;
   localparam int REL0_BIT = 9;
   localparam int ELEM0_LSB = 10;
   localparam int OFF4_BIT = 12;
   localparam int SEL1_LSB = 13;
   localparam int REL1_BIT = 22;
   localparam int ELEM1_LSB = 23;
   localparam int OFF5_BIT = 25;
   localparam int MODE_LSB = 26;
   localparam int PRED_LSB = 29;
   localparam int LAST_BIT = 31;
   // High word fields
   localparam int SEL2_LSB = 0;
   localparam int REL2_BIT = 9;
   localparam int ELEM2_LSB = 10;
   localparam int OFF1_BIT = 12;
   localparam int OPC_LSB = 13;
   localparam int ORDER_LSB = 18;
   localparam int ATOM_LSB = 21;
   localparam int OFF0_BIT = 27;
   localparam int OFF2_BIT = 28;
   localparam int OFF3_BIT = 31;
   localparam logic [4:0] INDEXED_SHARE_OPCODE = 5'h11;
   localparam logic [5:0] ATOM_WIDE_OFFSET = 6'h0F;
   localparam logic [2:0] ORDER_LAST_LEGAL = 3'h5;
   // Operand select ranges and special codes
   localparam logic [8:0] SEL_KBANK0 = 9'h080;
   localparam logic [8:0] SEL_KBANK1 = 9'h0A0;
   localparam logic [8:0] SEL_INLINE = 9'h0C0;
   localparam logic [8:0] SEL_KBANK2 = 9'h100;
   localparam logic [8:0] SEL_KBANK3 = 9'h120;
   localparam logic [8:0] SEL_LIMIT = 9'h140;
   localparam logic [8:0] SEL_SHARE_BASE = 9'h0D9;
   localparam logic [8:0] SEL_SHARE_SIZE = 9'h0DA;
   localparam logic [8:0] SEL_QUEUE_A_PEEK = 9'h0DB;
   localparam logic [8:0] SEL_QUEUE_B_PEEK = 9'h0DC;
   localparam logic [8:0] SEL_QUEUE_A_POP = 9'h0DD;
   localparam logic [8:0] SEL_QUEUE_B_POP = 9'h0DE;
   localparam logic [8:0] SEL_DIRECT_READ_A = 9'h0DF;
   localparam logic [8:0] SEL_DIRECT_READ_B = 9'h0E0;
   localparam logic [8:0] SEL_CLAUSE_TEMP = 9'h0E1;
   localparam logic [8:0] SEL_CYCLE_UPPER = 9'h0E3;
   localparam logic [8:0] SEL_CYCLE_LOWER = 9'h0E4;
   localparam logic [8:0] SEL_THREAD_MASK_UPPER = 9'h0E5;
   localparam logic [8:0] SEL_THREAD_MASK_LOWER = 9'h0E6;
   localparam logic [8:0] SEL_WAVE_INDEX = 9'h0EB;
   localparam logic [8:0] SEL_WAVE_COUNT = 9'h0EC;
   localparam logic [8:0] SEL_ODD_PATH = 9'h0ED;
   localparam logic [8:0] SEL_LOOP_COUNT = 9'h0EE;
   localparam logic [8:0] SEL_PARAM_BASE = 9'h0F0;
   localparam logic [8:0] SEL_PRIM_START = 9'h0F1;
   localparam logic [8:0] SEL_EXP_PRIM_UPPER = 9'h0F2;
   localparam logic [8:0] SEL_EXP_PRIM_LOWER = 9'h0F3;
   localparam logic [8:0] SEL_DBL_ONE_LOW = 9'h0F4;
   localparam logic [8:0] SEL_DBL_ONE_HIGH = 9'h0F5;
   localparam logic [8:0] SEL_DBL_HALF_LOW = 9'h0F6;
   localparam logic [8:0] SEL_DBL_HALF_HIGH = 9'h0F7;
   localparam logic [8:0] SEL_FLT_ZERO = 9'h0F8;
   localparam logic [8:0] SEL_FLT_ONE = 9'h0F9;
   localparam logic [8:0] SEL_INT_ONE = 9'h0FA;
   localparam logic [8:0] SEL_INT_MINUS_ONE = 9'h0FB;
   localparam logic [8:0] SEL_FLT_HALF = 9'h0FC;
   localparam logic [8:0] SEL_INLINE_LITERAL = 9'h0FD;
   localparam logic [8:0] SEL_PRIOR_VECTOR = 9'h0FE;
   // Constant bit patterns
   localparam logic [31:0] VAL_DBL_ONE_LOW = 32'h0000_0000;
   localparam logic [31:0] VAL_DBL_ONE_HIGH = 32'h3FF0_0000;
   localparam logic [31:0] VAL_DBL_HALF_LOW = 32'h0000_0000;
   localparam logic [31:0] VAL_DBL_HALF_HIGH = 32'h3FE0_0000;
   localparam logic [31:0] VAL_FLT_ZERO = 32'h0000_0000;
   localparam logic [31:0] VAL_FLT_ONE = 32'h3F80_0000;
   localparam logic [31:0] VAL_INT_ONE = 32'h0000_0001;
   localparam logic [31:0] VAL_INT_MINUS_ONE = 32'hFFFF_FFFF;
   localparam logic [31:0] VAL_FLT_HALF = 32'h3F00_0000;
   // Index modes and predicate gates
   localparam logic [2:0] ADD_ADDR_REG_X = 3'h0;
   localparam logic [2:0] ADD_LOOP_INDEX = 3'h4;
   localparam logic [2:0] ABSOLUTE_ONLY = 3'h5;
   localparam logic [2:0] ABSOLUTE_PLUS_ADDR_X = 3'h6;
   localparam logic [1:0] RUN_ALL_PIXELS = 2'h0;
   localparam logic [1:0] PRED_RESERVED = 2'h1;
   localparam logic [1:0] RUN_WHEN_FALSE = 2'h2;
   localparam logic [1:0] RUN_WHEN_TRUE = 2'h3;

   typedef enum logic [2:0] {
      LDSD_GENERAL_REGISTER, LDSD_KBANK0, LDSD_KBANK1, LDSD_INLINE,
      LDSD_KBANK2, LDSD_KBANK3, LDSD_RESERVED
   } ldsd_class_t;

   typedef struct packed {
      ldsd_class_t cls;
      logic [8:0] select;
      logic [8:0] address;
      logic absolute;
      logic [1:0] element;
      logic value_valid;
      logic [31:0] value;
   } ldsd_operand_t;

   typedef struct packed {
      logic [31:0] loop_count;
      logic [31:0] param_base;
      logic [15:0] prim_start_mask;
      logic [63:0] expanded_prim_mask;
      logic [31:0] share_base;
      logic [31:0] share_size;
      logic [31:0] queue_a;
      logic [31:0] queue_b;
      logic [31:0] clause_temp;
      logic [63:0] thread_mask;
      logic [31:0] wave_index;
      logic [31:0] wave_count;
      logic odd_path;
      logic [31:0] prior_vector;
      logic [31:0] inline_literal;
      logic [8:0] addr_reg_x;
   } ldsd_side_t;

   typedef struct packed {
      ldsd_operand_t [2:0] src;
      logic [1:0] predicate_gate;
      logic pred_reserved;
      logic last;
      logic opcode_ok;
      logic [2:0] load_order;
      logic vector_only_order;
      logic order_reserved;
      logic [5:0] atom_opcode;
      logic [11:0] index_offset;
      logic queue_pop;
      logic direct_read_a;
      logic direct_read_b;
      logic literal_used;
   } ldsd_decoded_t;
endpackage
`default_nettype wire

// file: hw/ldsd_decoder.sv
// Functional notes
// - Select 238 gives loop counter, 240 gives parameter cache base, as integers.
// - Select 241 gives per-quad primitive start mask, first quad bit implied.
// - Selects 242 and 243 give upper and lower expanded primitive mask.
// - Selects 244-252 give fixed double, float and integer constants.
// - Select 253 uses the inline literal, 254 the prior vector result.
// - Relative bit set adds the index-mode offset to the operand address.
// - Two-bit element field picks X, Y, Z or W.
// - Index mode picks address register X, loop index, absolute, absolute plus X.
// - Predicate gate: all, reserved, run when false, run when true.
// - Low word bit 31 marks the final pair; instruction then complete.
// - High word is the upper doubleword, low word the lower one.
// - Nine-bit select maps registers, constant banks and inline constants.
// - Selects 217 and 218 give local share base and size.
// - Selects 219/220 peek queues; 221/222 read and pop both at group end.
// - Selects 223/224 request direct share reads in A or B cycle.
// - Select 225 gives the clause temporary from the address init move.
// - Selects 227 and 228 give upper and lower free running cycle counter.
// - Selects 229 and 230 give upper and lower thread mask.
// - Select 235 gives wave index, 236 wave count in the group.
// - Select 237 gives 0 on even path, 1 on odd path.
// - High word opcode field must be 17; anything else is flagged.
// - Load order field 0-3 vector and scalar, 4-5 vector only.
// - Index offset gathered from scattered bits; atomic 15 scales by 64.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ldsd_decoder (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Instruction words from fetch
   input wire logic i_word_valid,
   input wire logic [31:0] i_word,
   // Operand side values
   input wire ldsd_pkg::ldsd_side_t i_side,
   // Decoded controls
   output logic o_dec_valid,
   output logic o_instr_done,
   output ldsd_pkg::ldsd_decoded_t o_dec,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);
   import ldsd_pkg::*;

   typedef enum logic {LDSD_WAIT_LOW, LDSD_WAIT_HIGH} ldsd_phase_t;

   typedef struct packed {
      ldsd_phase_t phase;
      logic [31:0] low_word;
      logic [31:0] high_word;
      logic [63:0] cycle_count;
      ldsd_decoded_t dec;
      logic dec_valid;
      logic instr_done;
      logic [31:0] ctrl;
      logic opcode_err;
      logic pred_rsvd;
      logic [31:0] pair_count;
      logic [31:0] prdata;
   } ldsd_state_t;

   ldsd_state_t s;
   ldsd_state_t next_s;

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic ldsd_class_t f_class(input logic [8:0] sel);
      ldsd_class_t c;
      c = LDSD_RESERVED;
      if (sel < SEL_KBANK0) begin
         c = LDSD_GENERAL_REGISTER;
      end else if (sel < SEL_KBANK1) begin
         c = LDSD_KBANK0;
      end else if (sel < SEL_INLINE) begin
         c = LDSD_KBANK1;
      end else if (sel < SEL_KBANK2) begin
         c = LDSD_INLINE;
      end else if (sel < SEL_KBANK3) begin
         c = LDSD_KBANK2;
      end else if (sel < SEL_LIMIT) begin
         c = LDSD_KBANK3;
      end
      return c;
   endfunction

   // Special operand values; data is zero and valid low for codes without one
   function automatic logic [32:0] f_value(input logic [8:0] sel, input ldsd_side_t sd,
                                           input logic [63:0] cnt);
      logic [32:0] v;
      v = 33'h0_0000_0000;
      case (sel)
         SEL_SHARE_BASE: v = {1'b1, sd.share_base};
         SEL_SHARE_SIZE: v = {1'b1, sd.share_size};
         SEL_QUEUE_A_PEEK, SEL_QUEUE_A_POP: v = {1'b1, sd.queue_a};
         SEL_QUEUE_B_PEEK, SEL_QUEUE_B_POP: v = {1'b1, sd.queue_b};
         SEL_CLAUSE_TEMP: v = {1'b1, sd.clause_temp};
         SEL_CYCLE_UPPER: v = {1'b1, cnt[63:32]};
         SEL_CYCLE_LOWER: v = {1'b1, cnt[31:0]};
         SEL_THREAD_MASK_UPPER: v = {1'b1, sd.thread_mask[63:32]};
         SEL_THREAD_MASK_LOWER: v = {1'b1, sd.thread_mask[31:0]};
         SEL_WAVE_INDEX: v = {1'b1, sd.wave_index};
         SEL_WAVE_COUNT: v = {1'b1, sd.wave_count};
         SEL_ODD_PATH: v = {1'b1, 31'h0000_0000, sd.odd_path};
         SEL_LOOP_COUNT: v = {1'b1, sd.loop_count};
         SEL_PARAM_BASE: v = {1'b1, sd.param_base};
         // First quad always starts a primitive, so its bit is forced
         SEL_PRIM_START: v = {1'b1, 16'h0000, sd.prim_start_mask[15:1], 1'b1};
         SEL_EXP_PRIM_UPPER: v = {1'b1, sd.expanded_prim_mask[63:32]};
         SEL_EXP_PRIM_LOWER: v = {1'b1, sd.expanded_prim_mask[31:0]};
         SEL_DBL_ONE_LOW: v = {1'b1, VAL_DBL_ONE_LOW};
         SEL_DBL_ONE_HIGH: v = {1'b1, VAL_DBL_ONE_HIGH};
         SEL_DBL_HALF_LOW: v = {1'b1, VAL_DBL_HALF_LOW};
         SEL_DBL_HALF_HIGH: v = {1'b1, VAL_DBL_HALF_HIGH};
         SEL_FLT_ZERO: v = {1'b1, VAL_FLT_ZERO};
         SEL_FLT_ONE: v = {1'b1, VAL_FLT_ONE};
         SEL_INT_ONE: v = {1'b1, VAL_INT_ONE};
         SEL_INT_MINUS_ONE: v = {1'b1, VAL_INT_MINUS_ONE};
         SEL_FLT_HALF: v = {1'b1, VAL_FLT_HALF};
         SEL_INLINE_LITERAL: v = {1'b1, sd.inline_literal};
         SEL_PRIOR_VECTOR: v = {1'b1, sd.prior_vector};
         default: v = 33'h0_0000_0000;
      endcase
      return v;
   endfunction

   function automatic ldsd_operand_t f_operand(input logic [8:0] sel, input logic rel,
                                               input logic [1:0] elem, input logic [2:0] mode,
                                               input ldsd_side_t sd, input logic [63:0] cnt);
      ldsd_operand_t op;
      logic [8:0] offset;
      logic [32:0] v;
      offset = 9'h000;
      v = f_value(sel, sd, cnt);
      op.cls = f_class(sel);
      op.select = sel;
      op.absolute = 1'b0;
      // Reserved index modes add nothing rather than guess an offset
      case (mode)
         ADD_ADDR_REG_X: offset = sd.addr_reg_x;
         ADD_LOOP_INDEX: offset = sd.loop_count[8:0];
         ABSOLUTE_ONLY: op.absolute = rel;
         ABSOLUTE_PLUS_ADDR_X: begin
            offset = sd.addr_reg_x;
            op.absolute = rel;
         end
         default: offset = 9'h000;
      endcase
      op.address = rel ? 9'(sel + offset) : sel;
      op.element = elem;
      op.value_valid = v[32];
      op.value = v[31:0];
      return op;
   endfunction

   function automatic logic f_is(input logic [8:0] a, input logic [8:0] b,
                                 input logic [8:0] c, input logic [8:0] code);
      return (a == code) || (b == code) || (c == code);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   logic [31:0] lo;
   logic [31:0] hi;
   logic [5:0] raw_offset;
   logic [8:0] sel0;
   logic [8:0] sel1;
   logic [8:0] sel2;
   logic setup;
   logic access;
   logic known;

   always_comb begin
      next_s = s;
      next_s.cycle_count = s.cycle_count + 64'h0000_0000_0000_0001;
      next_s.dec_valid = 1'b0;
      next_s.instr_done = 1'b0;
      // Word order within the pair: low doubleword first, then high
      lo = s.low_word;
      hi = i_word;
      sel0 = lo[SEL0_LSB +: 9];
      sel1 = lo[SEL1_LSB +: 9];
      sel2 = hi[SEL2_LSB +: 9];
      raw_offset = {lo[OFF5_BIT], lo[OFF4_BIT], hi[OFF3_BIT], hi[OFF2_BIT],
                    hi[OFF1_BIT], hi[OFF0_BIT]};
      setup = i_psel && !i_penable;
      access = i_psel && i_penable;
      known = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS) ||
              (i_paddr == ADDR_COUNT) || (i_paddr == ADDR_LOW) || (i_paddr == ADDR_HIGH);

      if (i_word_valid && s.ctrl[CTRL_ENABLE_BIT]) begin
         unique case (s.phase)
            LDSD_WAIT_LOW: begin
               next_s.low_word = i_word;
               next_s.phase = LDSD_WAIT_HIGH;
            end
            LDSD_WAIT_HIGH: begin
               next_s.high_word = i_word;
               next_s.phase = LDSD_WAIT_LOW;
               next_s.dec_valid = 1'b1;
               next_s.pair_count = s.pair_count + 32'h0000_0001;
               next_s.dec.src[0] = f_operand(sel0, lo[REL0_BIT], lo[ELEM0_LSB +: 2],
                                             lo[MODE_LSB +: 3], i_side, s.cycle_count);
               next_s.dec.src[1] = f_operand(sel1, lo[REL1_BIT], lo[ELEM1_LSB +: 2],
                                             lo[MODE_LSB +: 3], i_side, s.cycle_count);
               next_s.dec.src[2] = f_operand(sel2, hi[REL2_BIT], hi[ELEM2_LSB +: 2],
                                             lo[MODE_LSB +: 3], i_side, s.cycle_count);
               next_s.dec.predicate_gate = lo[PRED_LSB +: 2];
               next_s.dec.pred_reserved = (lo[PRED_LSB +: 2] == PRED_RESERVED);
               next_s.dec.last = lo[LAST_BIT];
               next_s.instr_done = lo[LAST_BIT];
               next_s.dec.opcode_ok = (hi[OPC_LSB +: 5] == INDEXED_SHARE_OPCODE);
               next_s.dec.load_order = hi[ORDER_LSB +: 3];
               next_s.dec.vector_only_order = hi[ORDER_LSB + 2];
               next_s.dec.order_reserved = (hi[ORDER_LSB +: 3] > ORDER_LAST_LEGAL);
               next_s.dec.atom_opcode = hi[ATOM_LSB +: 6];
               // Wide-stride atomic counts the offset in 64-dword units
               next_s.dec.index_offset = (hi[ATOM_LSB +: 6] == ATOM_WIDE_OFFSET) ?
                                         {raw_offset, 6'h00} : {6'h00, raw_offset};
               // Pop is only signalled with the final pair, when the group ends
               next_s.dec.queue_pop = lo[LAST_BIT] &&
                  (f_is(sel0, sel1, sel2, SEL_QUEUE_A_POP) ||
                   f_is(sel0, sel1, sel2, SEL_QUEUE_B_POP));
               next_s.dec.direct_read_a = f_is(sel0, sel1, sel2, SEL_DIRECT_READ_A);
               next_s.dec.direct_read_b = f_is(sel0, sel1, sel2, SEL_DIRECT_READ_B);
               // Direct reads take their address from the literal that follows
               next_s.dec.literal_used = f_is(sel0, sel1, sel2, SEL_INLINE_LITERAL) ||
                  next_s.dec.direct_read_a || next_s.dec.direct_read_b;
            end
         endcase
      end

      // Register reads are latched in setup so read data comes from a flop
      if (setup && !i_pwrite) begin
         next_s.prdata = 32'h0000_0000;
         case (i_paddr)
            ADDR_CTRL: next_s.prdata = s.ctrl;
            ADDR_STATUS: begin
               next_s.prdata[ST_OPCODE_ERR_BIT] = s.opcode_err;
               next_s.prdata[ST_PRED_RSVD_BIT] = s.pred_rsvd;
               next_s.prdata[ST_PHASE_BIT] = (s.phase == LDSD_WAIT_HIGH);
            end
            ADDR_COUNT: next_s.prdata = s.pair_count;
            ADDR_LOW: next_s.prdata = s.low_word;
            ADDR_HIGH: next_s.prdata = s.high_word;
            default: next_s.prdata = 32'h0000_0000;
         endcase
      end

      if (access && i_pwrite && i_pstrb[0]) begin
         if (i_paddr == ADDR_CTRL) begin
            next_s.ctrl = {31'h0000_0000, i_pwdata[CTRL_ENABLE_BIT]};
         end
         if (i_paddr == ADDR_STATUS) begin
            if (i_pwdata[ST_OPCODE_ERR_BIT]) begin
               next_s.opcode_err = 1'b0;
            end
            if (i_pwdata[ST_PRED_RSVD_BIT]) begin
               next_s.pred_rsvd = 1'b0;
            end
         end
      end

      // Sticky flags: a new event beats a clear in the same cycle
      if (next_s.dec_valid && !next_s.dec.opcode_ok) begin
         next_s.opcode_err = 1'b1;
      end
      if (next_s.dec_valid && next_s.dec.pred_reserved) begin
         next_s.pred_rsvd = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s <= '0;
         s.phase <= LDSD_WAIT_LOW;
         s.ctrl <= CTRL_RESET;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_dec = s.dec;
   assign o_dec_valid = s.dec_valid;
   assign o_instr_done = s.instr_done;
   assign o_prdata = s.prdata;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !known;
endmodule
`default_nettype wire

// file: bench/ldsd_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ldsd_checker
   import ldsd_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Instruction words
   input wire logic i_word_valid,
   input wire logic [31:0] i_word,
   // Decoded controls
   input wire logic o_dec_valid,
   input wire logic o_instr_done,
   input wire ldsd_pkg::ldsd_decoded_t o_dec
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////
   // A decode needs the low word two edges back and the high word one edge back
   sequence s_pair_taken; $past(i_word_valid, 2) && $past(i_word_valid); endsequence
   sequence s_pulse; o_dec_valid ##1 !o_dec_valid; endsequence
   property p_pulse; o_dec_valid |-> s_pulse; endproperty
   a_pulse: assert property (p_pulse) else $error("decode strobe too long");
   property p_cause; o_dec_valid |-> s_pair_taken; endproperty
   a_cause: assert property (p_cause) else $error("decode without a word pair");
   property p_hold; !o_dec_valid |-> $stable(o_dec); endproperty
   a_hold: assert property (p_hold) else $error("decoded controls moved");
   property p_opcode; o_dec_valid |-> o_dec.opcode_ok == ($past(i_word[17:13]) == 5'h11); endproperty
   a_opcode: assert property (p_opcode) else $error("opcode check wrong");
   property p_sel2; o_dec_valid |-> o_dec.src[2].select == $past(i_word[8:0]); endproperty
   a_sel2: assert property (p_sel2) else $error("third select wrong");
   property p_order; o_dec_valid |-> o_dec.load_order == $past(i_word[20:18]); endproperty
   a_order: assert property (p_order) else $error("load order wrong");
   property p_last; o_dec_valid |-> o_instr_done == $past(i_word[31], 2); endproperty
   a_last: assert property (p_last) else $error("completion flag wrong");
   property p_gate; o_dec_valid |-> o_dec.predicate_gate == $past(i_word[30:29], 2); endproperty
   a_gate: assert property (p_gate) else $error("predicate gate wrong");
endmodule
bind ldsd_decoder ldsd_checker ldsd_checker_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
   .i_word_valid(i_word_valid), .i_word(i_word), .o_dec_valid(o_dec_valid),
   .o_instr_done(o_instr_done), .o_dec(o_dec));
`default_nettype wire

// file: bench/ldsd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module ldsd_fetch_model (
   // Clock
   input wire logic i_ref_clk,
   // Pair request from the bench
   input wire logic i_go,
   input wire logic [63:0] i_pair,
   // Words towards the decoder
   output logic o_word_valid,
   output logic [31:0] o_word
);
   logic [31:0] hold_hi;
   logic busy;
   initial begin
      o_word_valid = 1'b0;
      o_word = 32'h0;
      busy = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   // Low doubleword first, high doubleword right after
   always @(posedge i_ref_clk) begin
      if (i_go) begin
         o_word_valid <= 1'b1;
         o_word <= i_pair[31:0];
         hold_hi <= i_pair[63:32];
         busy <= 1'b1;
      end else if (busy) begin
         o_word <= hold_hi;
         busy <= 1'b0;
      end else begin
         // Idle word keeps toggling so a stale word never passes for a real one
         o_word_valid <= 1'b0;
         o_word <= ~o_word;
      end
   end
endmodule
`default_nettype wire

// file: bench/lds_indexed_alu_operand_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lds_indexed_alu_operand_decoder_tb;
   import ldsd_pkg::*;
   logic i_ref_clk, i_sys_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
   logic o_dec_valid, o_instr_done, go, word_valid, seen, done, err;
   logic [7:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, word, q;
   logic [63:0] pair_w;
   ldsd_side_t side;
   ldsd_decoded_t o_dec;
   int errors = 0;
   int total_checks = 0;
   ldsd_fetch_model ldsd_fetch_model_i (.i_ref_clk(i_ref_clk), .i_go(go), .i_pair(pair_w),
      .o_word_valid(word_valid), .o_word(word));
   ldsd_decoder ldsd_decoder_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
      .i_word_valid(word_valid), .i_word(word), .i_side(side), .o_dec_valid(o_dec_valid),
      .o_instr_done(o_instr_done), .o_dec(o_dec), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(4'hF),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      #200000;
      errors++;
      summarize();
   end
   ////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] hiw(input logic [8:0] s, input logic [31:0] x);
      return x | {14'h0, INDEXED_SHARE_OPCODE, 4'h0, s};
   endfunction
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 16);
      q = o_prdata;
      err = o_pslverr;
      if (n >= 16) errors++;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      // One idle edge so the next setup never lands in the release step
      @(posedge i_ref_clk);
   endtask
   task automatic pair(input logic [31:0] lo, input logic [31:0] hi);
      go <= 1'b1;
      pair_w <= {hi, lo};
      @(posedge i_ref_clk);
      go <= 1'b0;
      seen = 1'b0;
      for (int n = 0; n < 8 && !seen; n++) begin
         @(negedge i_ref_clk);
         seen = o_dec_valid === 1'b1;
         done = o_instr_done;
      end
      @(posedge i_ref_clk);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_specials();
      logic [8:0] sels [18] = '{9'h0D9, 9'h0DD, 9'h0E1, 9'h0E3, 9'h0E5, 9'h0EC, 9'h0ED,
         9'h0EE, 9'h0F0, 9'h0F1, 9'h0F2, 9'h0F5, 9'h0F7, 9'h0F9, 9'h0FB, 9'h0FC, 9'h0FD, 9'h0FE};
      logic [31:0] exps [18] = '{32'h0000_1200, 32'hA5A5_0001, 32'h0C1A_0025, 32'h0,
         32'hF0F0_0000, 32'h4, 32'h1, 32'h3, 32'h200, 32'h1235, 32'h1111_2222, 32'h3FF0_0000,
         32'h3FE0_0000, 32'h3F80_0000, 32'hFFFF_FFFF, 32'h3F00_0000, 32'h253, 32'h5EC7_0254};
      logic [8:0] s;
      for (int i = 0; i < 18; i++) begin
         s = sels[i];
         pair(32'h8000_0000, hiw(s, 32'h0));
         chk(o_dec.src[2].value, exps[i]);
         chk({o_dec.queue_pop, o_dec.literal_used}, {s == 9'h0DD, s == 9'h0FD});
      end
      $display("t_specials done");
   endtask
   task automatic t_low();
      logic [8:0] sels [6] = '{9'h07F, 9'h080, 9'h0A0, 9'h0C0, 9'h100, 9'h120};
      for (int i = 0; i < 6; i++) begin
         pair({1'b0, 2'(i), 4'h0, 2'(i), 11'h0, 2'(i), 1'b0, sels[i]},
            hiw(9'h0, {20'h0, 2'(i), 10'h0}));
         chk(32'(o_dec.src[0].cls), 32'(i));
         chk({o_dec.src[0].element, o_dec.pred_reserved}, {2'(i), 1'(i % 4 == 1)});
         chk({o_dec.src[1].element, o_dec.src[2].element}, {2'(i), 2'(i)});
      end
      $display("t_low done");
   endtask
   task automatic t_rel();
      logic [2:0] modes [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h0};
      logic [8:0] offs [5] = '{9'h005, 9'h003, 9'h000, 9'h005, 9'h000};
      for (int i = 0; i < 5; i++) begin
         pair({3'h0, modes[i], 3'h0, 1'(i < 4), 9'h020, 3'h0, 1'(i < 4), 9'h010},
            hiw(9'h030, {22'h0, 1'(i < 4), 9'h0}));
         chk(o_dec.src[0].address, 9'h010 + offs[i]);
         chk(o_dec.src[1].address, 9'h020 + offs[i]);
         chk(o_dec.src[2].address, 9'h030 + offs[i]);
         chk(o_dec.src[0].absolute, 1'(i == 2 || i == 3));
      end
      $display("t_rel done");
   endtask
   task automatic t_flow();
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(q, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      pair(32'h001C_0000, hiw(9'h0DF, 32'h0800_0000));
      chk({seen, done, o_dec.index_offset}, {2'b10, 12'h001});
      chk({o_dec.direct_read_a, o_dec.direct_read_b, o_dec.literal_used}, 3'h7);
      pair(32'h8000_0000, hiw(9'h0, 32'h09F4_0000));
      chk({done, o_dec.direct_read_a, o_dec.index_offset}, {2'b10, 12'h040});
      chk({o_dec.load_order, o_dec.vector_only_order}, {3'h5, 1'b1});
      pair(32'h0, 32'h0018_A000);
      chk({o_dec.opcode_ok, o_dec.order_reserved}, 2'b01);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q[0], 1'b1);
      apb(1'b1, ADDR_STATUS, 32'h3);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q[1:0], 2'b00);
      apb(1'b1, ADDR_CTRL, 32'h0);
      pair(32'h0, hiw(9'h0, 32'h0));
      chk(seen, 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h1);
      $display("t_flow done");
   endtask
   initial begin
      i_sys_rst = 1'b1;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = 8'h0;
      i_pwdata = 32'h0;
      go = 1'b0;
      pair_w = 64'h0;
      side = '{share_base: 32'h1200, queue_a: 32'hA5A5_0001, clause_temp: 32'h0C1A_0025,
         thread_mask: 64'hF0F0_0000_0000_FFFF, wave_count: 32'h4, odd_path: 1'b1,
         loop_count: 32'h3, param_base: 32'h200, prim_start_mask: 16'h1234,
         expanded_prim_mask: 64'h1111_2222_3333_4444, prior_vector: 32'h5EC7_0254,
         inline_literal: 32'h253, addr_reg_x: 9'h005, default: '0};
      repeat (4) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_ref_clk);
      t_specials();
      t_low();
      t_rel();
      t_flow();
      summarize();
   end
endmodule
`default_nettype wire
